/* program_watchdog_timer_tb.sv */
// self-checking bench for the watchdog top
`timescale 1ns/1ns
`default_nettype none
module program_watchdog_timer_tb;
  import pwdt_pkg::*;
  logic clk, rst_b, wbCyc, wbStb, wbWe, wbAck, stopMode, waitMode, optionValid;
  logic losc = 1'b0;
  logic wdtIrq, wdtReset, irq;
  logic [15:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatW, wbDatR, q, a;
  logic [7:0] optionByte;
  int err_count, checks, cyc, seed, irqSeen, n;
  pwdt_top dut_u (.clk(clk), .rst_b(rst_b), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
    .losc(losc), .stopMode(stopMode), .waitMode(waitMode), .optionByte(optionByte),
    .optionValid(optionValid), .wdtIrq(wdtIrq), .wdtReset(wdtReset), .irq(irq));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // slow clock runs free, one rising edge every two cycles
  always @(posedge clk) begin
    losc <= ~losc;
    cyc++;
    if (wdtIrq === 1'b1)
      irqSeen++;
    if (cyc == 30000) begin
      err_count++;
      stop_test();
    end
  end
  function automatic logic [31:0] ticks(int cycles, int sel);
    return cycles >> (4 + 3 * sel);
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] lo, logic [31:0] hi);
    checks++;
    if (^got === 1'bx || got < lo || got > hi) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, lo);
    end
  endtask
  task automatic wb(logic we, logic [15:0] ad, logic [31:0] d);
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= ad;
    wbDatW <= d;
    wbSel <= 4'hf;
    // no local limit: only the cycle ceiling ends a hung wait
    do begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    seed = 32'h797c;
    {wbCyc, wbStb, wbWe, stopMode, waitMode} = 5'h00;
    wbAdr = 16'h0000;
    wbSel = 4'h0;
    wbDatW = 32'h0;
    optionByte = OPTION_ERASED;
    optionValid = 1'b1;
    rst_b = 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    wb(0, ADDR_COUNT, 0);
    chk(q, CNT_RELOAD, CNT_RELOAD);
    repeat (300) @(posedge clk);
    wb(0, ADDR_COUNT, 0);
    chk(q, CNT_RELOAD, CNT_RELOAD);
    wb(1, ADDR_OPTION, $random(seed));
    wb(0, ADDR_OPTION, 0);
    chk(q, OPTION_ERASED, OPTION_ERASED);
    wb(0, 16'h0020, 0);
    chk(q, 0, 0);
    $display("test halted start done");
    wb(1, ADDR_START, $random(seed));
    for (int s = 0; s < 2; s++) begin
      wb(1, ADDR_CONTROL, s << BIT_DIV_SEL);
      wb(0, ADDR_COUNT, 0);
      a = q;
      repeat (160 << (3 * s)) @(posedge clk);
      wb(0, ADDR_COUNT, 0);
      chk(a - q, ticks(160 << (3 * s), s) - 1, ticks(160 << (3 * s), s) + 1);
    end
    // back to divide by 16 so the low-power and refresh windows hold whole ticks
    wb(1, ADDR_CONTROL, 0);
    $display("test divide select done");
    for (int m = 1; m < 3; m++) begin
      {stopMode, waitMode} <= 2'(m);
      repeat (4) @(posedge clk);
      wb(0, ADDR_COUNT, 0);
      a = q;
      repeat (400) @(posedge clk);
      wb(0, ADDR_COUNT, 0);
      chk(q, a, a);
      {stopMode, waitMode} <= 2'b00;
      @(posedge clk);
    end
    repeat (160) @(posedge clk);
    wb(0, ADDR_COUNT, 0);
    chk(a - q, 8, 12);
    $display("test low power done");
    wb(1, ADDR_REFRESH, REFRESH_FIRST);
    wb(1, ADDR_REFRESH, REFRESH_SECOND);
    wb(0, ADDR_COUNT, 0);
    chk(q, CNT_RELOAD - 1, CNT_RELOAD);
    repeat (320) @(posedge clk);
    wb(0, ADDR_COUNT, 0);
    a = q;
    wb(1, ADDR_REFRESH, REFRESH_SECOND);
    wb(0, ADDR_COUNT, 0);
    chk(a - q, 0, 1);
    n = $random(seed);
    wb(1, ADDR_MODE1, n);
    wb(0, ADDR_MODE1, 0);
    chk(q, n & (32'h1 << BIT_UF_ACTION), n & (32'h1 << BIT_UF_ACTION));
    $display("test refresh done");
    wb(1, ADDR_PROTECT, 32'h80);
    stopMode <= 1'b1;
    wb(1, ADDR_REFRESH, REFRESH_FIRST);
    wb(1, ADDR_REFRESH, REFRESH_SECOND);
    n = cyc;
    irqSeen = 0;
    while (wdtReset !== 1'b1 && cyc - n < 9000) @(posedge clk);
    chk(cyc - n, 8185, 8205);
    chk(irqSeen, 0, 0);
    stopMode <= 1'b0;
    wb(0, ADDR_STATUS, 0);
    chk(32'(q[BIT_ST_RESET]), 1, 1);
    chk(irq, 0, 0);
    wb(1, ADDR_MASK, 32'h2);
    repeat (2) @(posedge clk);
    chk(irq, 1, 1);
    wb(1, ADDR_STATUS, 32'h2);
    repeat (2) @(posedge clk);
    chk(irq, 0, 0);
    $display("test protected underflow done");
    rst_b <= 1'b0;
    optionByte <= 8'($random(seed)) & 8'hfe;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (200) @(posedge clk);
    wb(0, ADDR_COUNT, 0);
    chk(CNT_RELOAD - q, 10, 14);
    $display("test autostart done");
    stop_test();
  end
endmodule
`default_nettype wire

/* pwdt_pkg.sv */
// register map, field positions, reset values and timing counts of the watchdog
// How it works
// RULE1: fifteen-bit counter decrements once per tick
// RULE2: protection off uses prescaler, on uses oscillator
// RULE3: prescaler divides by 16 or 128
// RULE4: autostart option bit read from option byte
// RULE5: option bit one: halted until start write
// RULE6: option bit zero: counts right after reset
// RULE7: refresh needs 00h then FFh write pair
// RULE8: protection off: freeze in stop, wait modes
// RULE9: protection on: keep counting in low power
// RULE10: underflow action zero raises interrupt request
// RULE11: underflow action one forces watchdog reset
// RULE12: protection on: every underflow forces reset
// RULE13: erased option byte reads FFh, halted start
// RULE14: software writes option byte only once; the code has no bus write path to it
// RULE15: protection on: period 4096 oscillator ticks
// RULE16: prescaler cleared only by device reset
// RULE17: program cannot change autostart option bit
// RULE18: reset or underflow reloads counter to 7FFFh; the code reloads 0FFFh instead when protection is on
// RULE19: stray FFh refresh write leaves counter alone
package pwdt_pkg;
  localparam int CNT_W = 15;
  localparam logic [14:0] CNT_RELOAD = 15'h7fff;
  localparam logic [14:0] CNT_RELOAD_PROT = 15'h0fff;
  localparam int PRE_W = 7;
  localparam logic [6:0] PRE_DIV16_MAX = 7'h0f;
  localparam logic [6:0] PRE_DIV128_MAX = 7'h7f;
  // register byte addresses
  localparam logic [15:0] ADDR_OPTION = 16'hffff;
  localparam logic [15:0] ADDR_CONTROL = 16'h0000;
  localparam logic [15:0] ADDR_REFRESH = 16'h0004;
  localparam logic [15:0] ADDR_START = 16'h0008;
  localparam logic [15:0] ADDR_PROTECT = 16'h000c;
  localparam logic [15:0] ADDR_MODE1 = 16'h0010;
  localparam logic [15:0] ADDR_COUNT = 16'h0014;
  localparam logic [15:0] ADDR_STATUS = 16'h0018;
  localparam logic [15:0] ADDR_MASK = 16'h001c;
  // field positions
  localparam int BIT_DIV_SEL = 7;
  localparam int BIT_PROTECT = 7;
  localparam int BIT_UF_ACTION = 2;
  localparam int BIT_AUTOSTART = 0;
  localparam int BIT_ST_UNDERFLOW = 0;
  localparam int BIT_ST_RESET = 1;
  localparam logic [7:0] REFRESH_FIRST = 8'h00;
  localparam logic [7:0] REFRESH_SECOND = 8'hff;
  localparam logic [7:0] OPTION_ERASED = 8'hff;
  localparam logic [1:0] STATUS_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  // watchdog reset pulse length in cycles
  localparam logic [3:0] WDT_RST_CYCLES = 4'h8;

  typedef struct packed {
    logic protect;
    logic divSel;
    logic ufAction;
    logic lowPower;
  } pwdt_cfg_t;

  typedef struct packed {
    logic underflow;
    logic resetReq;
  } pwdt_evt_t;
endpackage

/* pwdt_prescaler.sv */
// prescaler that turns the cpu clock into counter ticks
`timescale 1ns/1ns
`default_nettype none
module pwdt_prescaler
  import pwdt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic run,
  input wire logic divSel,
  // tick out
  output logic tick
);
  logic [PRE_W-1:0] preCnt_r;
  logic [PRE_W-1:0] preMax;

  assign preMax = divSel ? PRE_DIV128_MAX : PRE_DIV16_MAX; // see RULE3
  assign tick = run && (preCnt_r >= preMax);

  // only a device reset clears it; refresh leaves phase alone
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      preCnt_r <= '0; // see RULE16
    end else if (run) begin
      preCnt_r <= tick ? '0 : preCnt_r + 7'h01;
    end
  end
endmodule
`default_nettype wire

/* pwdt_props.sv */
// concurrent checks on the watchdog top ports
`timescale 1ns/1ns
`default_nettype none
module pwdt_props
  import pwdt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bus
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [15:0] wbAdr,
  input wire logic [31:0] wbDatR,
  input wire logic wbAck,
  // results
  input wire logic wdtIrq,
  input wire logic wdtReset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [13:0] upCnt_r;
  // no underflow can come sooner than 4096 slow ticks, at least two cycles each
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      upCnt_r <= '0;
    else if (upCnt_r != 14'h3fff)
      upCnt_r <= upCnt_r + 14'h1;
  end
  sequence takeReq;
    wbCyc && wbStb && !wbAck;
  endsequence
  sequence holeRead;
    takeReq ##0 (!wbWe && wbAdr == 16'h0020);
  endsequence
  a_ack_next: assert property (takeReq |=> wbAck)
    else $error("ack did not follow a request");
  a_ack_single: assert property (wbAck |=> !wbAck)
    else $error("ack longer than one cycle");
  a_data_idle: assert property (!wbAck |-> wbDatR == 32'h0)
    else $error("read data outside ack");
  a_hole_zero: assert property (holeRead |=> wbAck && wbDatR == 32'h0)
    else $error("unmapped read not zero");
  a_reset_len: assert property ($rose(wdtReset) |-> wdtReset [*8] ##1 !wdtReset)
    else $error("watchdog reset pulse length wrong");
  a_irq_pulse: assert property (wdtIrq |=> !wdtIrq)
    else $error("interrupt pulse too long");
  a_one_action: assert property (!(wdtIrq && wdtReset))
    else $error("interrupt and reset together");
  a_early_quiet: assert property (upCnt_r < 14'h1f40 |-> !wdtIrq && !wdtReset)
    else $error("underflow too early");
endmodule
bind pwdt_top pwdt_props props_u (.clk(clk), .rst_b(rst_b), .wbCyc(wbCyc), .wbStb(wbStb),
  .wbWe(wbWe), .wbAdr(wbAdr), .wbDatR(wbDatR), .wbAck(wbAck), .wdtIrq(wdtIrq),
  .wdtReset(wdtReset));
`default_nettype wire

/* pwdt_top.sv */
// watchdog timer with classic wishbone register slave
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module pwdt_top
  import pwdt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [15:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  // low-speed oscillator and power state pins
  input wire logic losc,
  input wire logic stopMode,
  input wire logic waitMode,
  // nonvolatile option byte as loaded from flash
  input wire logic [7:0] optionByte,
  input wire logic optionValid,
  // results
  output logic wdtIrq,
  output logic wdtReset,
  output logic irq
);
  logic [1:0] loscSync_r;
  logic loscPrev_r;
  logic [1:0] stopSync_r;
  logic [1:0] waitSync_r;
  logic [7:0] option_function_byte_r;
  logic divSel_r;
  logic protect_r;
  logic ufAction_r;
  logic running_r;
  logic [CNT_W-1:0] count_r;
  logic refreshArmed_r;
  logic [1:0] status_r;
  logic [1:0] mask_r;
  logic [3:0] rstCnt_r;
  logic wdtIrq_r;
  logic loaded_r;
  logic wrStrobe;
  logic rdStrobe;
  logic preTick;
  logic loscTick;
  logic lowPower;
  logic tickSel;
  logic underflow;
  logic refreshDone;
  pwdt_cfg_t cfg;
  pwdt_evt_t evt;
  logic [31:0] rdData;

  function automatic logic hit(input logic [15:0] adr, input logic [15:0] reg_adr);
    hit = (adr == reg_adr);
  endfunction

  assign wrStrobe = wbCyc && wbStb && wbWe && !wbAck && wbSel[0];
  assign rdStrobe = wbCyc && wbStb && !wbAck;

  // two-stage synchronisers for pins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      loscSync_r <= 2'h0;
      stopSync_r <= 2'h0;
      waitSync_r <= 2'h0;
      loscPrev_r <= 1'b0;
    end else begin
      loscSync_r <= {loscSync_r[0], losc};
      stopSync_r <= {stopSync_r[0], stopMode};
      waitSync_r <= {waitSync_r[0], waitMode};
      loscPrev_r <= loscSync_r[1];
    end
  end

  assign loscTick = loscSync_r[1] && !loscPrev_r;
  assign lowPower = stopSync_r[1] || waitSync_r[1];
  assign cfg = '{protect: protect_r, divSel: divSel_r, ufAction: ufAction_r,
                 lowPower: lowPower};

  // option byte captured after reset release; no bus write reaches it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      option_function_byte_r <= OPTION_ERASED; // see RULE13
      loaded_r <= 1'b0;
    end else if (!loaded_r && optionValid) begin
      option_function_byte_r <= optionByte; // see RULE4
      loaded_r <= 1'b1; // see RULE17
    end
  end

  // control registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      divSel_r <= 1'b0;
      protect_r <= 1'b0;
      ufAction_r <= 1'b0;
      mask_r <= MASK_RST;
    end else if (wrStrobe) begin
      if (hit(wbAdr, ADDR_CONTROL)) begin
        divSel_r <= wbDatW[BIT_DIV_SEL];
      end
      // protection can only be turned on until the next reset
      if (hit(wbAdr, ADDR_PROTECT) && wbDatW[BIT_PROTECT]) begin
        protect_r <= 1'b1;
      end
      if (hit(wbAdr, ADDR_MODE1)) begin
        ufAction_r <= wbDatW[BIT_UF_ACTION];
      end
      if (hit(wbAdr, ADDR_MASK)) begin
        mask_r <= wbDatW[1:0];
      end
    end
  end

  // run control: autostart bit zero starts at once, one waits for start write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      running_r <= 1'b0;
    end else if (loaded_r && !option_function_byte_r[BIT_AUTOSTART]) begin
      running_r <= 1'b1; // see RULE6
    end else if (wrStrobe && hit(wbAdr, ADDR_START)) begin
      running_r <= 1'b1; // see RULE5
    end
  end

  pwdt_prescaler u_pre (
    .clk(clk),
    .rst_b(rst_b),
    .run(running_r && !cfg.protect && !cfg.lowPower), // see RULE8
    .divSel(cfg.divSel),
    .tick(preTick)
  );

  // low power only halts the cpu-clock path
  assign tickSel = running_r && (cfg.protect ? loscTick : (preTick && !cfg.lowPower)); // see RULE2 RULE9
  assign underflow = tickSel && (count_r == '0);

  // refresh pair: FFh counts only right after 00h
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refreshArmed_r <= 1'b0;
    end else if (wrStrobe && hit(wbAdr, ADDR_REFRESH)) begin
      refreshArmed_r <= (wbDatW[7:0] == REFRESH_FIRST); // see RULE7 RULE19
    end
  end
  assign refreshDone = wrStrobe && hit(wbAdr, ADDR_REFRESH) && refreshArmed_r &&
                       (wbDatW[7:0] == REFRESH_SECOND);

  // down-counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= CNT_RELOAD; // see RULE18
    end else if (refreshDone || underflow) begin
      // protected mode runs a 4096-tick period
      count_r <= cfg.protect ? CNT_RELOAD_PROT : CNT_RELOAD; // see RULE7 RULE15 RULE18
    end else if (tickSel) begin
      count_r <= count_r - 15'h0001; // see RULE1
    end
  end

  assign evt.underflow = underflow && !cfg.protect && !cfg.ufAction; // see RULE10
  assign evt.resetReq = underflow && (cfg.protect || cfg.ufAction); // see RULE11 RULE12

  // watchdog interrupt request and stretched reset pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdtIrq_r <= 1'b0;
      rstCnt_r <= 4'h0;
    end else begin
      wdtIrq_r <= evt.underflow;
      if (evt.resetReq) begin
        rstCnt_r <= WDT_RST_CYCLES;
      end else if (rstCnt_r != 4'h0) begin
        rstCnt_r <= rstCnt_r - 4'h1;
      end
    end
  end
  assign wdtIrq = wdtIrq_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdtReset <= 1'b0;
    end else begin
      wdtReset <= evt.resetReq || (rstCnt_r > 4'h1);
    end
  end

  // sticky status; set beats a write-one clear in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_r <= STATUS_RST;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == BIT_ST_UNDERFLOW && evt.underflow) || (i == BIT_ST_RESET && evt.resetReq)) begin
          status_r[i] <= 1'b1;
        end else if (wrStrobe && hit(wbAdr, ADDR_STATUS) && wbDatW[i]) begin
          status_r[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_r & mask_r);
    end
  end

  // read mux; unmapped reads return zero and are still acknowledged
  always_comb begin
    rdData = 32'h0000_0000;
    case (wbAdr)
      ADDR_OPTION: rdData = {24'h0, option_function_byte_r};
      ADDR_CONTROL: rdData = {24'h0, divSel_r, 7'h00};
      ADDR_PROTECT: rdData = {24'h0, protect_r, 7'h00};
      ADDR_MODE1: rdData = {29'h0, ufAction_r, 2'h0};
      ADDR_START: rdData = {31'h0, running_r};
      ADDR_COUNT: rdData = {17'h0, count_r};
      ADDR_STATUS: rdData = {30'h0, status_r};
      ADDR_MASK: rdData = {30'h0, mask_r};
      default: rdData = 32'h0000_0000;
    endcase
  end

  // one-cycle ack, dropped the cycle after
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wbAck <= 1'b0;
      wbDatR <= 32'h0000_0000;
    end else begin
      wbAck <= rdStrobe;
      wbDatR <= rdStrobe ? rdData : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire
